// file: design/hpc_config_regs.sv
// port configuration register slice, offsets 6h to ah
// Overview of operation
// R1: charge enable bit 0 drives port 1, bit 1 drives port 2.
// R2: charge enable bits load from the strap terminals when reset releases.
// R3: in configuration mode loader or host writes update charge enables.
// R4: charge register bits 7:2 are read-only and read zero.
// R5: override bit 7 set makes removable status come from stored flags.
// R6: removable flag bit n describes port n+1; 1 means removable.
// R7: override clear makes flags read-only, reading inverted fuse non-removable field.
// R8: removable bits 6:2 read zero; bits 3:2 still take writes.
// R9: port-used byte is read-only; writes leave it unchanged.
// R10: outside agent keeps reserved tuning bits at their defaults.
// R11: config byte two: bits 7,0 read-only, bits 6:1 writable.
// R12: config byte two bit 5 loads inverted polarity terminal at reset release.
// R13: writes to read-only or reserved bits are dropped without error.
module hpc_config_regs
    import hpc_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 srst,
    input  wire logic [1:0]           power_charge_select_pins,
    input  wire logic                 power_enable_polarity_pin,
    input  wire logic [NUM_PORTS-1:0] otp_non_removable,
    input  wire logic                 cfg_mode_enable,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    output logic      [7:0]           reg_rdata,
    output logic                      reg_rvalid,
    output logic      [NUM_PORTS-1:0] port_charge_enable,
    output logic      [NUM_PORTS-1:0] port_removable,
    output logic                      removable_override_enable,
    output logic                      power_enable_polarity_bit,
    output logic      [7:0]           dev_cfg2,
    output logic      [7:0]           phy_tuning
);
    typedef struct packed {
        logic       in_reset;
        logic [7:0] charge;
        logic [7:0] removable;
        logic [7:0] phy;
        logic [7:0] cfg2;
        logic [7:0] rdata;
        logic       rvalid;
    } hpc_state_s;

    hpc_state_s st_q;
    hpc_state_s st_d;
    hpc_strap_if strap ();

    hpc_strap_sync u_strap (
        .clk_sys                   (clk_sys),
        .power_charge_select_pins  (power_charge_select_pins),
        .power_enable_polarity_pin (power_enable_polarity_pin),
        .strap                     (strap.src)
    );

    function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                         input logic [7:0] mask);
        merge = (old_v & ~mask) | (new_v & mask); // R13
    endfunction : merge

    logic [NUM_PORTS-1:0] removable_view;
    logic                 release_now;
    logic                 wr_ok;

    // override picks stored flags, else fuse inverse
    assign removable_view = st_q.removable[RMV_OVERRIDE_BIT] ? st_q.removable[NUM_PORTS-1:0]
                                                             : ~otp_non_removable; // R5 R7
    assign release_now    = st_q.in_reset & ~srst;
    assign wr_ok          = reg_wr & cfg_mode_enable; // R3

    always_comb begin
        st_d          = st_q;
        st_d.rvalid   = 1'b0;
        // strap load is a one-edge event; a flag left high would block every write
        st_d.in_reset = 1'b0;
        if (release_now) begin
            st_d.charge[1:0]            = strap.charge_sel;  // R2
            st_d.cfg2[CFG2_POL_BIT]     = ~strap.polarity;   // R12
        end else if (wr_ok) begin
            case (reg_addr)
                OFS_CHARGE_EN: begin
                    st_d.charge = merge(st_q.charge, reg_wdata, CHARGE_WMASK); // R1 R4
                end
                OFS_REMOVABLE: begin
                    st_d.removable = merge(st_q.removable, reg_wdata, RMV_HIDDEN_WMASK); // R8
                    st_d.removable[RMV_OVERRIDE_BIT] = reg_wdata[RMV_OVERRIDE_BIT];
                    // flags only take writes while override is already set
                    if (st_q.removable[RMV_OVERRIDE_BIT]) begin
                        st_d.removable[1:0] = reg_wdata[1:0]; // R6 R7
                    end
                end
                OFS_PHY_TUNE: begin
                    st_d.phy = merge(st_q.phy, reg_wdata, PHY_WMASK); // R10
                end
                OFS_DEV_CFG2: begin
                    st_d.cfg2 = merge(st_q.cfg2, reg_wdata, CFG2_WMASK); // R11
                end
                default: begin
                    st_d.charge = st_q.charge; // R9 R13
                end
            endcase
        end
        if (reg_rd) begin
            st_d.rvalid = 1'b1;
            case (reg_addr)
                OFS_CHARGE_EN: st_d.rdata = st_q.charge & CHARGE_WMASK; // R4
                OFS_REMOVABLE: st_d.rdata = {st_q.removable[RMV_OVERRIDE_BIT], 5'h00, removable_view}; // R8
                OFS_PORT_USED: st_d.rdata = PORT_USED_RST; // R9
                OFS_PHY_TUNE:  st_d.rdata = st_q.phy & PHY_WMASK;
                OFS_DEV_CFG2:  st_d.rdata = st_q.cfg2 & CFG2_WMASK; // R11
                default:       st_d.rdata = 8'h00;
            endcase
        end
        if (srst) begin
            st_d           = '0;
            st_d.in_reset  = 1'b1;
            st_d.removable = RMV_RST;
            st_d.phy       = PHY_TUNE_RST;
            st_d.cfg2      = CFG2_RST;
        end
    end

    always_ff @(posedge clk_sys) begin
        st_q <= st_d;
    end

    assign reg_rdata                 = st_q.rdata;
    assign reg_rvalid                = st_q.rvalid;
    assign port_charge_enable        = st_q.charge[NUM_PORTS-1:0]; // R1
    assign port_removable            = removable_view; // R6
    assign removable_override_enable = st_q.removable[RMV_OVERRIDE_BIT];
    assign power_enable_polarity_bit = st_q.cfg2[CFG2_POL_BIT];
    assign dev_cfg2                  = st_q.cfg2;
    assign phy_tuning                = st_q.phy;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence s_release;
        st_q.in_reset && !srst;
    endsequence
    // the strap load edge drops writes, so it is kept out of every write step
    sequence s_wr(logic [7:0] a);
        reg_wr && cfg_mode_enable && !st_q.in_reset && reg_addr == a;
    endsequence
    sequence s_rd(logic [7:0] a);
        reg_rd && reg_addr == a && !(reg_wr && cfg_mode_enable);
    endsequence
    // removable write with the flags still locked, then with them open
    sequence s_rmv_locked_wr;
        reg_wr && cfg_mode_enable && !st_q.in_reset && reg_addr == OFS_REMOVABLE
            && !removable_override_enable;
    endsequence
    sequence s_rmv_open_wr;
        reg_wr && cfg_mode_enable && !st_q.in_reset && reg_addr == OFS_REMOVABLE
            && removable_override_enable && reg_wdata[RMV_OVERRIDE_BIT];
    endsequence
    sequence s_rd_unmapped;
        reg_rd && (reg_addr < OFS_CHARGE_EN || reg_addr > OFS_DEV_CFG2);
    endsequence

    AST_CHARGE_WRITE: assert property (s_wr(OFS_CHARGE_EN) |=> port_charge_enable == $past(reg_wdata[1:0])) // R1
        else $error("charge enable did not follow write");
    AST_CHARGE_STRAP: assert property (s_release |=> port_charge_enable == $past(strap.charge_sel)) // R2
        else $error("charge enable not loaded from straps");
    AST_STRAP_ONCE: assert property (s_release |=> !st_q.in_reset) // R2
        else $error("strap load flag stuck");
    AST_NO_MODE_WRITE: assert property (reg_wr && !cfg_mode_enable && !st_q.in_reset // R3
                                        |=> $stable(port_charge_enable) && $stable(dev_cfg2))
        else $error("write taken outside configuration mode");
    AST_NO_MODE_OTHER: assert property (reg_wr && !cfg_mode_enable && !st_q.in_reset // R3
                                        |=> $stable(removable_override_enable) && $stable(phy_tuning))
        else $error("write taken outside configuration mode");
    AST_CHARGE_UPPER: assert property (s_rd(OFS_CHARGE_EN) |=> reg_rvalid && reg_rdata[7:2] == 6'h00) // R4
        else $error("charge upper bits not zero");
    AST_CHARGE_READ: assert property (s_rd(OFS_CHARGE_EN) |=> reg_rdata[1:0] == $past(port_charge_enable)) // R1
        else $error("charge readback wrong");
    AST_RMV_VIEW: assert property (s_rmv_open_wr |=> port_removable == $past(reg_wdata[1:0])) // R5
        else $error("removable status not taken from flags");
    AST_OVERRIDE_WRITE: assert property (s_wr(OFS_REMOVABLE) // R5
                                         |=> removable_override_enable == $past(reg_wdata[RMV_OVERRIDE_BIT]))
        else $error("override bit did not follow write");
    AST_RMV_LOCKED: assert property (s_rmv_locked_wr |=> $stable(st_q.removable[1:0])) // R7
        else $error("locked removable flags changed");
    AST_RMV_HIDDEN: assert property (s_wr(OFS_REMOVABLE) // R8
                                     |=> st_q.removable[3:2] == $past(reg_wdata[3:2]))
        else $error("hidden removable bits not stored");
    AST_RMV_READ: assert property (s_rd(OFS_REMOVABLE) |=> reg_rdata[6:2] == 5'h00 // R8
                                   && reg_rdata[1:0] == $past(port_removable))
        else $error("removable readback wrong");
    AST_RMV_FUSE: assert property (!removable_override_enable && !st_q.in_reset // R7
                                   |-> port_removable == ~otp_non_removable)
        else $error("fuse inverse not shown");
    AST_PORT_USED: assert property (s_rd(OFS_PORT_USED) |=> reg_rdata == PORT_USED_RST) // R9
        else $error("port used byte changed");
    AST_PORT_USED_WR: assert property (s_wr(OFS_PORT_USED) |=> $stable(port_charge_enable) // R9
                                       && $stable(dev_cfg2) && $stable(phy_tuning) && $stable(removable_override_enable))
        else $error("port used write disturbed state");
    AST_PHY_WRITE: assert property (s_wr(OFS_PHY_TUNE) |=> phy_tuning == ($past(reg_wdata) & PHY_WMASK)) // R10
        else $error("tuning byte write wrong");
    AST_PHY_READ: assert property (s_rd(OFS_PHY_TUNE) |=> reg_rdata == $past(phy_tuning)) // R13
        else $error("tuning byte readback wrong");
    AST_CFG2_RO: assert property (s_wr(OFS_DEV_CFG2) |=> dev_cfg2[7] == 1'b0 && dev_cfg2[0] == 1'b0 // R11
                                  && dev_cfg2[6:1] == $past(reg_wdata[6:1]))
        else $error("config byte two access wrong");
    AST_CFG2_READ: assert property (s_rd(OFS_DEV_CFG2) |=> reg_rdata == $past(dev_cfg2) // R11
                                    && reg_rdata[7] == 1'b0 && reg_rdata[0] == 1'b0)
        else $error("config byte two readback wrong");
    AST_POL_STRAP: assert property (s_release |=> power_enable_polarity_bit == !$past(strap.polarity)) // R12
        else $error("polarity bit not inverted strap");

    // read answer: one pulse per strobe, data held between reads
    AST_READ_TIMING: assert property (reg_rd |=> reg_rvalid ##1 !reg_rvalid || $past(reg_rd)) // R13
        else $error("read answer timing wrong");
    AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata) && !reg_rvalid) // R13
        else $error("read data moved without a read");
    AST_UNMAPPED_READ: assert property (s_rd_unmapped |=> reg_rvalid && reg_rdata == 8'h00) // R13
        else $error("unmapped read not zero");
endmodule : hpc_config_regs

// file: design/hpc_strap_sync.sv
// two-flop synchronisers for the strap terminals
module hpc_strap_sync
    import hpc_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic [1:0] power_charge_select_pins,
    input  wire logic       power_enable_polarity_pin,
    hpc_strap_if.src        strap
);
    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] sync;
    } hpc_sync_s;

    hpc_sync_s st_q;
    hpc_sync_s st_d;

    // no reset: the chain must carry live pin levels through reset
    always_comb begin
        st_d      = st_q;
        st_d.meta = {power_enable_polarity_pin, power_charge_select_pins};
        st_d.sync = st_q.meta;
    end

    always_ff @(posedge clk_sys) begin
        st_q <= st_d;
    end

    assign strap.charge_sel = st_q.sync[1:0];
    assign strap.polarity   = st_q.sync[2];
endmodule : hpc_strap_sync

// file: dv/hpc_host_model.sv
// behavioural configuration host issuing single byte register transfers
module hpc_host_model (
    input  wire logic       clk_sys,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end
    // one strobe cycle, result taken just after the edge that ends it
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic v);
        @(posedge clk_sys);
        reg_wr    <= wr;
        reg_rd    <= ~wr;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        // released lines never keep the last value, so stale data cannot pass
        reg_addr  <= ~a;
        reg_wdata <= ~d;
        #1;
        q = reg_rdata;
        v = reg_rvalid;
    endtask : xfer
endmodule : hpc_host_model

// file: dv/tb.sv
// self-checking bench for the port configuration register slice
module tb import hpc_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk_sys, srst, pol_pin, cfg_mode_enable, reg_wr, reg_rd, reg_rvalid;
    logic       removable_override_enable, power_enable_polarity_bit;
    logic [1:0] pins, otp, port_charge_enable, port_removable;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, dev_cfg2, phy_tuning;
    int         n_mismatch, compares, cycles;
    hpc_config_regs hpc_config_regs_i (.clk_sys, .srst, .power_charge_select_pins(pins),
        .power_enable_polarity_pin(pol_pin), .otp_non_removable(otp), .cfg_mode_enable, .reg_wr,
        .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .port_charge_enable, .port_removable,
        .removable_override_enable, .power_enable_polarity_bit, .dev_cfg2, .phy_tuning);
    hpc_host_model hpc_host_model_i (.clk_sys, .reg_rdata, .reg_rvalid, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata);
    always #4 clk_sys = ~clk_sys;
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop
    // transfers take two cycles each, so this ceiling is far beyond need
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic       v;
        hpc_host_model_i.xfer(1'b1, a, d, q, v);
    endtask : wr
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        logic       v;
        hpc_host_model_i.xfer(1'b0, a, 8'h00, q, v);
        chk({name, " valid"}, {7'h00, v}, 8'h01);
        chk(name, q, exp);
    endtask : rd_chk
    task automatic t_reset();
        chk("charge", {6'h00, port_charge_enable}, 8'h02);
        chk("cfg2", dev_cfg2, 8'h20);
        chk("removable", {6'h00, port_removable}, 8'h02);
        rd_chk("rd06", OFS_CHARGE_EN, 8'h02);
        rd_chk("rd07", OFS_REMOVABLE, 8'h02);
        rd_chk("rd0a", OFS_DEV_CFG2, 8'h20);
        $display("test reset done");
    endtask : t_reset
    task automatic t_charge();
        wr(OFS_CHARGE_EN, 8'hff);
        chk("charge", {6'h00, port_charge_enable}, 8'h03);
        rd_chk("rd06", OFS_CHARGE_EN, 8'h03);
        wr(OFS_CHARGE_EN, 8'h01);
        chk("charge", {6'h00, port_charge_enable}, 8'h01);
        cfg_mode_enable <= 1'b0;
        wr(OFS_CHARGE_EN, 8'h02);
        chk("charge", {6'h00, port_charge_enable}, 8'h01);
        cfg_mode_enable <= 1'b1;
        $display("test charge done");
    endtask : t_charge
    task automatic t_removable();
        wr(OFS_REMOVABLE, 8'h03);
        chk("removable", {6'h00, port_removable}, 8'h02);
        wr(OFS_REMOVABLE, 8'h80);
        chk("override", {7'h00, removable_override_enable}, 8'h01);
        wr(OFS_REMOVABLE, 8'h8d);
        chk("removable", {6'h00, port_removable}, 8'h01);
        rd_chk("rd07", OFS_REMOVABLE, 8'h81);
        $display("test removable done");
    endtask : t_removable
    task automatic t_readonly();
        wr(OFS_PORT_USED, 8'hff);
        rd_chk("rd08", OFS_PORT_USED, 8'h00);
        wr(OFS_PHY_TUNE, 8'hdc);
        rd_chk("rd09", OFS_PHY_TUNE, 8'h00);
        chk("phy", phy_tuning, 8'h00);
        wr(OFS_DEV_CFG2, 8'hff);
        chk("cfg2", dev_cfg2, 8'h7e);
        rd_chk("rd0a", OFS_DEV_CFG2, 8'h7e);
        wr(OFS_DEV_CFG2, 8'h00);
        chk("polarity", {7'h00, power_enable_polarity_bit}, 8'h00);
        rd_chk("rd30", 8'h30, 8'h00);
        $display("test readonly done");
    endtask : t_readonly
    task automatic t_rereset();
        @(posedge clk_sys);
        srst <= 1'b1;
        pins <= 2'b11;
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk("charge", {6'h00, port_charge_enable}, 8'h03);
        chk("cfg2", dev_cfg2, 8'h20);
        chk("override", {7'h00, removable_override_enable}, 8'h00);
        chk("removable", {6'h00, port_removable}, 8'h02);
        wr(OFS_CHARGE_EN, 8'h02);
        chk("charge", {6'h00, port_charge_enable}, 8'h02);
        $display("test rereset done");
    endtask : t_rereset
    initial begin
        clk_sys = 1'b0;
        srst = 1'b1;
        pins = 2'b10;
        pol_pin = 1'b0;
        otp = 2'b01;
        cfg_mode_enable = 1'b1;
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        // strap load edge, checked once its update has landed
        @(posedge clk_sys);
        #1;
        t_reset();
        t_charge();
        t_removable();
        t_readonly();
        t_rereset();
        report_and_stop();
    end
endmodule : tb

// file: inc/hpc_pkg.sv
// constants for the hub port configuration register slice
package hpc_pkg;
    localparam int unsigned NUM_PORTS           = 2;
    localparam logic [7:0]  OFS_CHARGE_EN       = 8'h06;
    localparam logic [7:0]  OFS_REMOVABLE       = 8'h07;
    localparam logic [7:0]  OFS_PORT_USED       = 8'h08;
    localparam logic [7:0]  OFS_PHY_TUNE        = 8'h09;
    localparam logic [7:0]  OFS_DEV_CFG2        = 8'h0a;
    // field positions
    localparam int unsigned RMV_OVERRIDE_BIT    = 7;
    localparam int unsigned CFG2_POL_BIT        = 5;
    // write masks: bits that hold storage
    localparam logic [7:0]  CHARGE_WMASK        = 8'h03;
    localparam logic [7:0]  RMV_FLAG_WMASK      = 8'h03;
    localparam logic [7:0]  RMV_HIDDEN_WMASK    = 8'h0c;
    localparam logic [7:0]  PHY_WMASK           = 8'h23;
    localparam logic [7:0]  CFG2_WMASK          = 8'h7e;
    // reset values
    localparam logic [7:0]  PORT_USED_RST       = 8'h00;
    localparam logic [7:0]  PHY_TUNE_RST        = 8'h00;
    localparam logic [7:0]  CFG2_RST            = 8'h00;
    localparam logic [7:0]  RMV_RST             = 8'h00;
endpackage : hpc_pkg

// file: inc/hpc_strap_if.sv
// synchronised strap levels passed from the pin stage to the register slice
interface hpc_strap_if;
    logic [1:0] charge_sel;
    logic       polarity;
    modport src (output charge_sel, output polarity);
    modport dst (input  charge_sel, input  polarity);
endinterface : hpc_strap_if
